//--- common/exc_pkg.sv
// package: constants and carriers for the program / fp / decrementer exception unit
package exc_pkg;

  localparam int          VEC_W            = 20;
  localparam logic [19:0] VEC_PROGRAM      = 20'h00700;
  localparam logic [19:0] VEC_FP_UNAVAIL   = 20'h00800;
  localparam logic [19:0] VEC_DECREMENTER  = 20'h00900;
  localparam logic [19:0] VEC_RESV_LO      = 20'h00A00;
  localparam logic [19:0] VEC_RESV_HI      = 20'h00BFF;
  localparam logic [19:0] VEC_RESET_VALUE  = 20'h00000;

  // cause bit positions in the saved status word (low nibble of cause field)
  localparam int          CAUSE_W          = 4;
  localparam int          CAUSE_FP_EN      = 0;
  localparam int          CAUSE_ILLEGAL    = 1;
  localparam int          CAUSE_PRIV       = 2;
  localparam int          CAUSE_TRAP       = 3;
  localparam logic [3:0]  CAUSE_RESET      = 4'h0;

  localparam int          SPR_FIELD_W      = 10;
  localparam int          DEC_W_DEFAULT    = 32;

  // machine state bits of interest
  typedef struct packed {
    logic fp_exc_mode_bit0;
    logic fp_exc_mode_bit1;
    logic user_privilege_bit;
    logic fp_available_bit;
    logic external_enable_bit;
  } msr_bits_s;

  // one instruction presented for completion
  typedef struct packed {
    logic                   valid;
    logic                   is_fp;
    logic                   opcode_invalid;
    logic                   is_privileged;
    logic                   is_spr_move;
    logic [SPR_FIELD_W-1:0] special_register_field;
    logic                   spr_field_invalid;
    logic                   is_trap;
    logic                   trap_cond_true;
    logic                   fp_raises_enabled;
    logic                   is_fp_status_control_move;
    logic                   fp_status_control_move_exc_en;
  } instr_s;

  typedef enum logic [2:0] {
    EXC_NONE,
    EXC_PROGRAM,
    EXC_FP_UNAVAIL,
    EXC_DECREMENTER
  } exc_kind_e;

  function automatic logic vec_reserved(input logic [19:0] v);
    return (v >= VEC_RESV_LO) && (v <= VEC_RESV_HI);
  endfunction

endpackage

//--- logic/exc_unit.sv
// exception recognition and vectoring for program, fp unavailable and decrementer cases
`timescale 1ns/10ps

//
// Function
// - program exception at 00700, cause bits saved
// - fp enabled when mode bit and summary
// - summary set by fp op or move
// - invalid opcode raises illegal instruction
// - privileged op in user mode traps
// - invalid spr move with msb set privileged
// - trap condition true raises trap
// - fp op with fp unavailable at 00800
// - counter msb rising edge requests 00900
// - decrementer taken only with external enable
// - fp enabled exceptions always precise
module exc_unit
  import exc_pkg::*;
#(
  parameter int DEC_W = DEC_W_DEFAULT
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // machine state and counter
  input  wire msr_bits_s        machine_state_word,
  input  wire logic [DEC_W-1:0] down_counter,
  // fp status summary control
  input  wire logic             fp_status_control_clear_summary,
  // instruction at completion
  input  wire instr_s           instr,
  // exception outputs
  output logic                  exc_take,
  output logic [VEC_W-1:0]      exc_vector,
  output logic [CAUSE_W-1:0]    saved_restore_status,
  output logic                  fp_enabled_summary,
  output logic                  dec_pending,
  output logic                  instr_blocked
);

  logic       dec_msb_prev;
  logic       dec_edge;
  logic       fp_mode_on;
  logic       summary_set;
  logic       next_summary;
  logic       cause_fp_en;
  logic       cause_illegal;
  logic       cause_priv;
  logic       cause_trap;
  logic       spr_priv;
  logic       prog_any;
  logic       fp_unavail;
  logic       dec_take;
  logic       next_dec_pending;
  exc_kind_e  kind;
  logic [19:0] next_vector;
  logic [3:0]  next_cause;

  // summary set by an enabled fp op or a status move leaving exc+enable set
  // an fp op stopped as unavailable never executes, so it cannot set the summary
  assign summary_set = instr.valid & ~fp_unavail & ((instr.is_fp & instr.fp_raises_enabled)
                       | (instr.is_fp_status_control_move & instr.fp_status_control_move_exc_en));
  // set wins over clear so a coincident event is not lost
  assign next_summary = summary_set | (fp_enabled_summary & ~fp_status_control_clear_summary);

  assign fp_mode_on  = machine_state_word.fp_exc_mode_bit0
                     | machine_state_word.fp_exc_mode_bit1;
  // checked at the instruction's own completion, so reporting stays precise
  assign cause_fp_en = instr.valid & fp_mode_on & next_summary;
  assign cause_illegal = instr.valid & instr.opcode_invalid;
  assign spr_priv = instr.is_spr_move & instr.spr_field_invalid
                  & instr.special_register_field[SPR_FIELD_W-1];
  assign cause_priv = instr.valid & machine_state_word.user_privilege_bit
                    & (instr.is_privileged | spr_priv);
  assign cause_trap = instr.valid & instr.is_trap & instr.trap_cond_true;
  assign fp_unavail = instr.valid & instr.is_fp
                    & ~machine_state_word.fp_available_bit;
  assign prog_any   = ~fp_unavail & (cause_fp_en | cause_illegal | cause_priv | cause_trap);

  assign dec_edge = ~dec_msb_prev & down_counter[DEC_W-1];
  // held until the enable opens and no instruction fault competes; masked otherwise
  assign dec_take = (dec_pending | dec_edge) & machine_state_word.external_enable_bit
                  & ~fp_unavail & ~prog_any;
  assign next_dec_pending = (dec_pending | dec_edge) & ~dec_take;

  // instruction-caused exceptions outrank the asynchronous decrementer
  assign kind = fp_unavail ? EXC_FP_UNAVAIL :
                prog_any   ? EXC_PROGRAM    :
                dec_take   ? EXC_DECREMENTER : EXC_NONE;

  always_comb begin
    case (kind)
      EXC_PROGRAM:     next_vector = VEC_PROGRAM;
      EXC_FP_UNAVAIL:  next_vector = VEC_FP_UNAVAIL;
      EXC_DECREMENTER: next_vector = VEC_DECREMENTER;
      default:         next_vector = exc_vector;
    endcase
  end

  assign next_cause = {cause_trap, cause_priv, cause_illegal, cause_fp_en};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exc_take             <= 1'b0;
      exc_vector           <= VEC_RESET_VALUE;
      saved_restore_status <= CAUSE_RESET;
      fp_enabled_summary   <= 1'b0;
      dec_pending          <= 1'b0;
      dec_msb_prev         <= 1'b0;
      instr_blocked        <= 1'b0;
    end else begin
      exc_take           <= (kind != EXC_NONE) & ~vec_reserved(next_vector);
      exc_vector         <= next_vector;
      fp_enabled_summary <= next_summary;
      dec_pending        <= next_dec_pending;
      dec_msb_prev       <= down_counter[DEC_W-1];
      instr_blocked      <= fp_unavail | prog_any;
      if (kind == EXC_PROGRAM) begin
        saved_restore_status <= next_cause;
      end
    end
  end

endmodule

//--- dv/exc_props.sv
// port assertions for the exception unit
`timescale 1ns/10ps
module exc_props
  import exc_pkg::*;
#(parameter int DEC_W = 32) (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire msr_bits_s          machine_state_word,
  input wire logic [DEC_W-1:0]   down_counter,
  input wire logic               fp_status_control_clear_summary,
  input wire instr_s             instr,
  input wire logic               exc_take,
  input wire logic [VEC_W-1:0]   exc_vector,
  input wire logic [CAUSE_W-1:0] saved_restore_status,
  input wire logic               fp_enabled_summary,
  input wire logic               dec_pending,
  input wire logic               instr_blocked
);
  wire msr_bits_s  m = machine_state_word;
  wire [3:0]       s = saved_restore_status;
  wire             fu = instr.valid & instr.is_fp & !m.fp_available_bit;
  wire             ok = instr.valid & !fu;
  wire             up = ok & m.user_privilege_bit;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  fp_unav_a: assert property (fu |=> exc_take && instr_blocked && exc_vector == VEC_FP_UNAVAIL)
    else $error("fp unavailable missed");
  illegal_op_a: assert property (ok && instr.opcode_invalid |=> exc_take && s[CAUSE_ILLEGAL]
    && exc_vector == VEC_PROGRAM) else $error("illegal op missed");
  priv_op_a: assert property (up && instr.is_privileged |=> s[CAUSE_PRIV])
    else $error("privileged op missed");
  spr_priv_a: assert property (up && instr.is_spr_move && instr.spr_field_invalid
    && instr.special_register_field[SPR_FIELD_W-1] |=> s[CAUSE_PRIV]) else $error("spr move missed");
  fp_en_a: assert property (ok && (m.fp_exc_mode_bit0 | m.fp_exc_mode_bit1)
    && fp_enabled_summary && !fp_status_control_clear_summary |=> s[CAUSE_FP_EN]) else $error("fp enabled missed");
  summary_set_a: assert property (ok && instr.is_fp_status_control_move && instr.fp_status_control_move_exc_en
    |=> fp_enabled_summary) else $error("summary not set");
  dec_edge_a: assert property ($rose(down_counter[DEC_W-1]) && m.external_enable_bit
    && !instr.valid |=> exc_take && exc_vector == VEC_DECREMENTER) else $error("dec missed");
  dec_mask_a: assert property (!m.external_enable_bit |=> !(exc_take && exc_vector == VEC_DECREMENTER))
    else $error("dec taken masked");
  trap_op_a: assert property (ok && instr.is_trap && instr.trap_cond_true
    |=> exc_take && s[CAUSE_TRAP]) else $error("trap missed");
  dec_wait_a: assert property (dec_pending && m.external_enable_bit && fu
    |=> dec_pending) else $error("dec lost to fault");
  no_resv_a: assert property (exc_take |-> !vec_reserved(exc_vector))
    else $error("reserved vector taken");
endmodule
bind exc_unit exc_props #(.DEC_W(DEC_W)) chk (.*);

//--- dv/tb_top.sv
// random stimulus and cycle model for the exception unit
`timescale 1ns/10ps
module tb_top;
  import exc_pkg::*;
  logic             clk_sys = 0;
  logic             reset_n = 0;
  logic             fp_status_control_clear_summary = 0;
  msr_bits_s        machine_state_word = '0;
  logic [3:0]       down_counter = '0;
  instr_s           instr = '0;
  logic             exc_take, fp_enabled_summary, dec_pending, instr_blocked;
  logic [VEC_W-1:0] exc_vector, e_vec;
  logic [3:0]       saved_restore_status, e_sr, c;
  logic             e_tk, e_sum, e_pd, e_bk, prev, fu, pe, su, td, ev;
  int               error_cnt = 0, n_tests = 0, cyc = 0;
  wire msr_bits_s   m = machine_state_word;
  wire instr_s      i = instr;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
  // small counter width so the msb toggles often
  exc_unit #(.DEC_W(4)) uut (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic close_out;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(48));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1;
    repeat (3000) begin
      @(posedge clk_sys);
      instr <= instr_s'(21'($urandom));
      machine_state_word <= msr_bits_s'(5'($urandom));
      down_counter <= 4'($urandom);
      fp_status_control_clear_summary <= 1'($urandom);
    end
    close_out;
  end
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      {e_tk, e_sum, e_pd, e_bk, prev, e_sr, e_vec} = '0;
    end else begin
      fu = i.valid & i.is_fp & !m.fp_available_bit;
      su = e_sum & !fp_status_control_clear_summary
           | i.valid & !fu & (i.is_fp & i.fp_raises_enabled
           | i.is_fp_status_control_move & i.fp_status_control_move_exc_en);
      c = {i.is_trap & i.trap_cond_true, m.user_privilege_bit & (i.is_privileged
           | i.is_spr_move & i.spr_field_invalid & i.special_register_field[9]),
           i.opcode_invalid, (m.fp_exc_mode_bit0 | m.fp_exc_mode_bit1) & su};
      pe = i.valid & !fu & |c;
      // an instruction fault wins, so the counter event waits
      ev = e_pd | down_counter[3] & !prev;
      td = ev & m.external_enable_bit & !fu & !pe;
      e_pd = ev & !td;
      prev = down_counter[3];
      e_tk = fu | pe | td;
      e_bk = fu | pe;
      e_sum = su;
      if (pe) e_sr = c;
      if (e_tk) e_vec = fu ? VEC_FP_UNAVAIL : pe ? VEC_PROGRAM : VEC_DECREMENTER;
    end
  end
  always @(negedge clk_sys) begin
    cyc++;
    if (reset_n) begin
      `CHK(exc_take, e_tk)
      `CHK(exc_vector, e_vec)
      `CHK(saved_restore_status, e_sr)
      `CHK(fp_enabled_summary, e_sum)
      `CHK(dec_pending, e_pd)
      `CHK(instr_blocked, e_bk)
    end
    if (cyc > 4000) begin
      error_cnt++;
      close_out;
    end
  end
endmodule
